// ===== ismmu_top.v
// Purpose: Internal SRAM code and data mapping units plus the DMA region guard.
// Assumes: Requesters and the register port are logic on mclk; no synchronisers are needed.
// Notes: Every answer appears registered one cycle after its request.
//
// Contract
// RULE_01 - Each mapping unit holds sixteen entries, one per physical page.
// RULE_02 - Processes 0 and 1 bypass entries, full access, identity page mapping.
// RULE_03 - Entries and page-size registers change only on writes from process 0 or 1.
// RULE_04 - Entry bits 6:4 grant none, all, or one named process 2 to 7.
// RULE_05 - Entry bits 3:0 name the virtual page redirected onto its physical page.
// RULE_06 - Processes 2 to 7 reach the physical page whose entry names and grants them.
// RULE_07 - Code-side unit serves instruction bus and refuses writes from processes 2 to 7.
// RULE_08 - Data-side unit serves data bus and allows granted reads and writes.
// RULE_09 - DMA guard keeps one permit bit per 8 KB region across two registers.
// RULE_10 - DMA decision uses only the permit bit, never the process identifier.
// RULE_11 - Set permit bit allows DMA access; cleared bit denies it.
// RULE_12 - Permit bits map regions in ascending order from the first bank base.
// RULE_13 - DMA permit registers change only on writes from process 0 or 1.
// RULE_14 - Software reloads both permit registers on every context switch.
// RULE_15 - Page size is 8, 4 or 2 KB by mode 0, 1 or 2; sixteen pages.
// RULE_16 - Page n starts at the unit base plus n times the page size.
// RULE_17 - Memory beyond the pages is open only to processes 0 and 1.
// RULE_18 - Unmapped or unpermitted accesses by processes 2 to 7 are refused.
// RULE_19 - A refused DMA transfer performs no memory access in the guarded banks.
`timescale 1ns/1ps
`default_nettype none
`include "ismmu_regs.vh"

module ismmu_top (
	// Clock and reset.
	input  wire        mclk,
	input  wire        rst_n,
	// Register port.
	input  wire        reg_we,
	input  wire        reg_re,
	input  wire [5:0]  reg_idx,
	input  wire [31:0] reg_wdata,
	input  wire [2:0]  reg_pid,
	output reg  [31:0] reg_rdata_q,
	output reg         reg_refused_q,
	// Instruction bus request and answer.
	input  wire        ibus_valid,
	input  wire [31:0] ibus_addr,
	input  wire        ibus_write,
	input  wire [2:0]  ibus_pid,
	output wire        ibus_rsp_valid,
	output wire        ibus_hit,
	output wire        ibus_grant,
	output wire [31:0] ibus_phys_addr,
	// Data bus request and answer.
	input  wire        dbus_valid,
	input  wire [31:0] dbus_addr,
	input  wire        dbus_write,
	input  wire [2:0]  dbus_pid,
	output wire        dbus_rsp_valid,
	output wire        dbus_hit,
	output wire        dbus_grant,
	output wire [31:0] dbus_phys_addr,
	// DMA request and answer.
	input  wire        dma_valid,
	input  wire [31:0] dma_addr,
	input  wire        dma_write,
	output reg         dma_rsp_valid_q,
	output reg         dma_hit_q,
	output reg         dma_grant_q,
	output reg         dma_mem_en_q,
	output reg         dma_mem_write_q,
	output reg  [31:0] dma_mem_addr_q
);

	reg  [31:0] permit_low_q;
	reg  [31:0] permit_high_q;
	reg  [31:0] rdata_d;
	wire        wr_priv;
	wire        wr_ok;
	wire        code_entry_sel;
	wire        data_entry_sel;
	wire [6:0]  code_rd_entry;
	wire [6:0]  data_rd_entry;
	wire [1:0]  code_rd_mode;
	wire [1:0]  data_rd_mode;
	wire [31:0] dma_diff;
	wire [31:0] dma_region;
	wire        dma_in;
	wire [63:0] permit_all;
	wire        dma_bit;

	localparam [5:0] CODE_ENTRY_IDX = `ISMMU_IDX_CODE_ENTRY;
	localparam [5:0] DATA_ENTRY_IDX = `ISMMU_IDX_DATA_ENTRY;

	assign wr_priv        = (reg_pid[2:1] == 2'b00);
	assign wr_ok          = reg_we && wr_priv; // RULE_03 RULE_13
	assign code_entry_sel = (reg_idx[5:4] == CODE_ENTRY_IDX[5:4]);
	assign data_entry_sel = (reg_idx[5:4] == DATA_ENTRY_IDX[5:4]);

	ismmu_map #(
		.BASE      (`ISMMU_CODE_BASE),
		.READ_ONLY (1)
	) u_code_map (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.cfg_we_entry (wr_ok && code_entry_sel), // RULE_03
		.cfg_idx      (reg_idx[3:0]),
		.cfg_wdata    (reg_wdata[6:0]),
		.cfg_we_mode  (wr_ok && (reg_idx == `ISMMU_IDX_CODE_MODE)), // RULE_03
		.cfg_mode     (reg_wdata[1:0]),
		.rd_idx       (reg_idx[3:0]),
		.rd_entry     (code_rd_entry),
		.rd_mode      (code_rd_mode),
		.acc_valid    (ibus_valid), // RULE_07
		.acc_addr     (ibus_addr),
		.acc_write    (ibus_write),
		.acc_pid      (ibus_pid),
		.rsp_valid_q  (ibus_rsp_valid),
		.rsp_hit_q    (ibus_hit),
		.rsp_grant_q  (ibus_grant),
		.rsp_addr_q   (ibus_phys_addr)
	);

	ismmu_map #(
		.BASE      (`ISMMU_DATA_BASE),
		.READ_ONLY (0)
	) u_data_map (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.cfg_we_entry (wr_ok && data_entry_sel), // RULE_03
		.cfg_idx      (reg_idx[3:0]),
		.cfg_wdata    (reg_wdata[6:0]),
		.cfg_we_mode  (wr_ok && (reg_idx == `ISMMU_IDX_DATA_MODE)), // RULE_03
		.cfg_mode     (reg_wdata[1:0]),
		.rd_idx       (reg_idx[3:0]),
		.rd_entry     (data_rd_entry),
		.rd_mode      (data_rd_mode),
		.acc_valid    (dbus_valid), // RULE_08
		.acc_addr     (dbus_addr),
		.acc_write    (dbus_write),
		.acc_pid      (dbus_pid),
		.rsp_valid_q  (dbus_rsp_valid),
		.rsp_hit_q    (dbus_hit),
		.rsp_grant_q  (dbus_grant),
		.rsp_addr_q   (dbus_phys_addr)
	);

	assign dma_diff   = dma_addr - `ISMMU_DMA_BASE;
	assign dma_region = dma_diff >> `ISMMU_DMA_SHIFT;
	assign dma_in     = dma_region < {25'h0, `ISMMU_DMA_REGIONS}; // RULE_09
	assign permit_all = {permit_high_q, permit_low_q}; // RULE_12
	assign dma_bit    = permit_all[dma_region[5:0]]; // RULE_10 RULE_11

	always @* begin
		rdata_d = 32'h0;
		if (code_entry_sel) begin
			rdata_d = {25'h0, code_rd_entry};
		end else if (data_entry_sel) begin
			rdata_d = {25'h0, data_rd_entry};
		end else begin
			case (reg_idx)
				`ISMMU_IDX_CODE_MODE:   rdata_d = {30'h0, code_rd_mode};
				`ISMMU_IDX_DATA_MODE:   rdata_d = {30'h0, data_rd_mode};
				`ISMMU_IDX_PERMIT_LOW:  rdata_d = permit_low_q;
				`ISMMU_IDX_PERMIT_HIGH: rdata_d = permit_high_q;
				default:                rdata_d = 32'h0;
			endcase
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			permit_low_q    <= `ISMMU_PERMIT_RESET;
			permit_high_q   <= `ISMMU_PERMIT_RESET;
			reg_rdata_q     <= 32'h0;
			reg_refused_q   <= 1'b0;
			dma_rsp_valid_q <= 1'b0;
			dma_hit_q       <= 1'b0;
			dma_grant_q     <= 1'b0;
			dma_mem_en_q    <= 1'b0;
			dma_mem_write_q <= 1'b0;
			dma_mem_addr_q  <= 32'h0;
		end else begin
			if (wr_ok && (reg_idx == `ISMMU_IDX_PERMIT_LOW)) begin
				permit_low_q <= reg_wdata; // RULE_13
			end
			if (wr_ok && (reg_idx == `ISMMU_IDX_PERMIT_HIGH)) begin
				permit_high_q <= reg_wdata; // RULE_13
			end
			if (reg_re) begin
				reg_rdata_q <= rdata_d;
			end
			reg_refused_q   <= reg_we && !wr_priv; // RULE_03 RULE_13
			dma_rsp_valid_q <= dma_valid;
			dma_hit_q       <= dma_valid && dma_in;
			dma_grant_q     <= dma_valid && (!dma_in || dma_bit); // RULE_11
			dma_mem_en_q    <= dma_valid && (!dma_in || dma_bit); // RULE_19
			dma_mem_write_q <= dma_valid && dma_write && (!dma_in || dma_bit); // RULE_19
			if (dma_valid) begin
				dma_mem_addr_q <= dma_addr;
			end
		end
	end

endmodule
`default_nettype wire

// ===== ismmu_regs.vh
// Purpose: Constants for the internal SRAM mapping units and DMA region guard.
// Assumes: Register indices are local to the block's own register port.
// Notes: Reset values are all zero, so pages start closed to processes 2 to 7 and DMA regions start closed to every DMA transfer.
`ifndef ISMMU_REGS_VH
`define ISMMU_REGS_VH

`define ISMMU_IDX_CODE_ENTRY   6'h00
`define ISMMU_IDX_DATA_ENTRY   6'h10
`define ISMMU_IDX_CODE_MODE    6'h20
`define ISMMU_IDX_DATA_MODE    6'h21
`define ISMMU_IDX_PERMIT_LOW   6'h22
`define ISMMU_IDX_PERMIT_HIGH  6'h23

`define ISMMU_RIGHTS_MSB       6
`define ISMMU_RIGHTS_LSB       4
`define ISMMU_VPAGE_MSB        3
`define ISMMU_VPAGE_LSB        0
`define ISMMU_RIGHTS_NONE      3'h0
`define ISMMU_RIGHTS_ALL       3'h1

`define ISMMU_MODE_8K          2'h0
`define ISMMU_MODE_4K          2'h1
`define ISMMU_MODE_2K          2'h2
`define ISMMU_SHIFT_8K         5'h0d
`define ISMMU_SHIFT_4K         5'h0c
`define ISMMU_SHIFT_2K         5'h0b

`define ISMMU_CODE_BASE        32'h40080000
`define ISMMU_DATA_BASE        32'h3ffc0000
`define ISMMU_REGION_BYTES     32'h00020000

`define ISMMU_DMA_BASE         32'h3ffae000
`define ISMMU_DMA_REGIONS      7'h29
`define ISMMU_DMA_SHIFT        5'h0d

`define ISMMU_ENTRY_RESET      7'h00
`define ISMMU_MODE_RESET       2'h0
`define ISMMU_PERMIT_RESET     32'h00000000

`endif

// ===== ismmu_map.v
// Purpose: One internal SRAM mapping unit with sixteen per-physical-page entries.
// Assumes: Write permission by process identifier is checked by the instantiating module.
// Notes: Answer is registered one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
`include "ismmu_regs.vh"

module ismmu_map #(
	parameter [31:0] BASE      = `ISMMU_CODE_BASE,
	parameter        READ_ONLY = 1
) (
	// Clock and reset.
	input  wire        mclk,
	input  wire        rst_n,
	// Configuration writes and reads.
	input  wire        cfg_we_entry,
	input  wire [3:0]  cfg_idx,
	input  wire [6:0]  cfg_wdata,
	input  wire        cfg_we_mode,
	input  wire [1:0]  cfg_mode,
	input  wire [3:0]  rd_idx,
	output wire [6:0]  rd_entry,
	output wire [1:0]  rd_mode,
	// Access request.
	input  wire        acc_valid,
	input  wire [31:0] acc_addr,
	input  wire        acc_write,
	input  wire [2:0]  acc_pid,
	// Access answer.
	output reg         rsp_valid_q,
	output reg         rsp_hit_q,
	output reg         rsp_grant_q,
	output reg  [31:0] rsp_addr_q
);

	reg  [6:0]  entry_q [0:15];
	reg  [1:0]  mode_q;
	reg  [4:0]  shift;
	reg         found;
	reg  [3:0]  ppage;
	reg         grant_d;
	reg  [31:0] addr_d;
	wire [31:0] diff;
	wire [31:0] pg;
	wire [31:0] mask;
	wire        in_rgn;
	wire        in_pages;
	wire        priv;
	integer     i;
	integer     j;

	assign diff     = acc_addr - BASE;
	assign in_rgn   = diff < `ISMMU_REGION_BYTES;
	assign pg       = diff >> shift;
	assign in_pages = (pg[31:4] == 28'h0);
	assign mask     = (32'h1 << shift) - 32'h1;
	assign priv     = (acc_pid[2:1] == 2'b00);
	assign rd_entry = entry_q[rd_idx];
	assign rd_mode  = mode_q;

	always @* begin
		case (mode_q) // RULE_15
			`ISMMU_MODE_4K: shift = `ISMMU_SHIFT_4K;
			`ISMMU_MODE_2K: shift = `ISMMU_SHIFT_2K;
			default:        shift = `ISMMU_SHIFT_8K;
		endcase
	end

	always @* begin
		found = 1'b0;
		ppage = 4'h0;
		for (i = 15; i >= 0; i = i - 1) begin
			if ((entry_q[i][`ISMMU_VPAGE_MSB:`ISMMU_VPAGE_LSB] == pg[3:0]) &&
			    ((entry_q[i][`ISMMU_RIGHTS_MSB:`ISMMU_RIGHTS_LSB] == `ISMMU_RIGHTS_ALL) ||
			     (entry_q[i][`ISMMU_RIGHTS_MSB:`ISMMU_RIGHTS_LSB] == acc_pid))) begin // RULE_04 RULE_06
				found = 1'b1;
				ppage = i[3:0];
			end
		end
	end

	always @* begin
		grant_d = 1'b0;
		addr_d  = acc_addr;
		if (in_rgn) begin
			if (priv) begin
				grant_d = 1'b1; // RULE_02
				addr_d  = acc_addr;
			end else if (in_pages && found && !(READ_ONLY && acc_write)) begin // RULE_07 RULE_08 RULE_17 RULE_18
				grant_d = 1'b1;
				addr_d  = BASE + ((({28'h0, ppage}) << shift) | (diff & mask)); // RULE_05 RULE_06 RULE_16
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (j = 0; j < 16; j = j + 1) begin
				entry_q[j] <= `ISMMU_ENTRY_RESET;
			end
			mode_q      <= `ISMMU_MODE_RESET;
			rsp_valid_q <= 1'b0;
			rsp_hit_q   <= 1'b0;
			rsp_grant_q <= 1'b0;
			rsp_addr_q  <= 32'h0;
		end else begin
			if (cfg_we_entry) begin
				entry_q[cfg_idx] <= cfg_wdata; // RULE_01
			end
			if (cfg_we_mode) begin
				mode_q <= cfg_mode;
			end
			rsp_valid_q <= acc_valid;
			rsp_hit_q   <= acc_valid && in_rgn;
			rsp_grant_q <= acc_valid && in_rgn && grant_d;
			if (acc_valid) begin
				rsp_addr_q <= addr_d;
			end
		end
	end

endmodule
`default_nettype wire

// ===== ismmu_requester.sv
// Purpose: Requester model for the instruction, data and DMA request ports.
// Assumes: One request at a time, launched at a falling edge and held one cycle.
// Notes: The address is inverted once a request ends so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module ismmu_requester (
	// Clock.
	input  wire logic        mclk,
	// Shared request lines; valid bit 0 instruction, 1 data, 2 DMA.
	output var  logic [2:0]  valid,
	output var  logic [31:0] addr,
	output var  logic        write,
	output var  logic [2:0]  process_identifier
);
	initial begin
		valid = 3'h0;
		addr = 32'h0;
		write = 1'b0;
		process_identifier = 3'h0;
	end
	task automatic go(input logic [1:0] b, input logic [31:0] a, input logic w,
		input logic [2:0] p);
		@(negedge mclk);
		valid[b] = 1'b1;
		addr = a;
		write = w;
		process_identifier = p;
		@(negedge mclk);
		valid = 3'h0;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

// ===== ismmu_top_assertions.sv
// Purpose: Port-level checks of the mapping units and DMA guard.
// Assumes: All answers are registered one cycle after the request.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none
module ismmu_checker (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        reg_we,
	input wire logic [2:0]  reg_pid,
	input wire logic        reg_refused_q,
	input wire logic        ibus_valid,
	input wire logic        ibus_write,
	input wire logic [2:0]  ibus_pid,
	input wire logic        ibus_rsp_valid,
	input wire logic        ibus_hit,
	input wire logic        ibus_grant,
	input wire logic        dbus_valid,
	input wire logic [31:0] dbus_addr,
	input wire logic [2:0]  dbus_pid,
	input wire logic        dbus_rsp_valid,
	input wire logic        dbus_hit,
	input wire logic        dbus_grant,
	input wire logic [31:0] dbus_phys_addr,
	input wire logic        dma_valid,
	input wire logic [31:0] dma_addr,
	input wire logic        dma_write,
	input wire logic        dma_rsp_valid_q,
	input wire logic        dma_hit_q,
	input wire logic        dma_grant_q,
	input wire logic        dma_mem_en_q,
	input wire logic        dma_mem_write_q,
	input wire logic [31:0] dma_mem_addr_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_dma_req;
		dma_valid ##1 dma_rsp_valid_q;
	endsequence
	code_write_refused_a: assert property (
		ibus_valid && ibus_write && ibus_pid > 3'h1 |=> ibus_rsp_valid && !ibus_grant)
		else $error("code write granted");
	grant_needs_hit_a: assert property (
		ibus_grant |-> ibus_hit && ibus_rsp_valid) else $error("grant outside region");
	bypass_identity_a: assert property (
		dbus_valid && dbus_pid < 3'h2 && dbus_addr[31:17] == 15'h1ffe
		|=> dbus_grant && dbus_phys_addr == $past(dbus_addr)) else $error("bypass broken");
	offset_kept_a: assert property (
		dbus_rsp_valid && dbus_grant |-> dbus_phys_addr[10:0] == $past(dbus_addr[10:0]))
		else $error("page offset changed");
	data_outside_a: assert property (
		dbus_valid && dbus_addr[31:17] != 15'h1ffe |=> !dbus_grant)
		else $error("data grant outside region");
	dma_refused_quiet_a: assert property (
		s_dma_req |-> dma_mem_en_q == dma_grant_q) else $error("memory enable mismatch");
	dma_pass_outside_a: assert property (
		dma_valid && dma_addr < 32'h3ffae000 |=> dma_grant_q && !dma_hit_q)
		else $error("DMA outside banks blocked");
	reg_refusal_a: assert property (
		reg_we |=> reg_refused_q == ($past(reg_pid) > 3'h1)) else $error("refusal wrong");
	data_hit_range_a: assert property (
		dbus_valid |=> dbus_hit == ($past(dbus_addr[31:17]) == 15'h1ffe))
		else $error("data hit wrong");
	dma_write_gated_a: assert property (
		s_dma_req |-> dma_mem_write_q == ($past(dma_write) && dma_grant_q) &&
		dma_mem_addr_q == $past(dma_addr)) else $error("DMA memory strobe wrong");
endmodule
bind ismmu_top ismmu_checker ismmu_checker_i (.mclk, .rst_n, .reg_we, .reg_pid,
	.reg_refused_q, .ibus_valid, .ibus_write, .ibus_pid, .ibus_rsp_valid, .ibus_hit,
	.ibus_grant, .dbus_valid, .dbus_addr, .dbus_pid, .dbus_rsp_valid, .dbus_hit,
	.dbus_grant, .dbus_phys_addr, .dma_valid, .dma_addr, .dma_write, .dma_rsp_valid_q,
	.dma_hit_q, .dma_grant_q, .dma_mem_en_q, .dma_mem_write_q, .dma_mem_addr_q);
`default_nettype wire

// ===== test_ismmu_top.sv
// Purpose: Self-checking bench for the mapping units and DMA guard.
// Assumes: Inputs change at falling edges; answers are read at the next falling edge.
// Notes: Bus 0 is instruction, 1 data, 2 DMA.
`timescale 1ns/1ps
`default_nettype none
module test_ismmu_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_we = 1'b0;
	logic        reg_re = 1'b0;
	logic [5:0]  reg_idx = 6'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [2:0]  reg_pid = 3'h0;
	wire  [31:0] reg_rdata_q, ibus_phys_addr, dbus_phys_addr, addr;
	wire         reg_refused_q, ibus_grant, dbus_grant, dma_grant_q, dma_mem_en_q, write;
	wire  [2:0]  valid, process_identifier;
	wire  [2:0]  grant = {dma_grant_q, dbus_grant, ibus_grant};
	int          n_errors = 0;
	int          checked = 0;
	always #2.5 mclk = ~mclk;
	ismmu_requester ismmu_requester_i (.mclk, .valid, .addr, .write, .process_identifier);
	ismmu_top ismmu_top_i (.mclk, .rst_n, .reg_we, .reg_re, .reg_idx, .reg_wdata,
		.reg_pid, .reg_rdata_q, .reg_refused_q, .ibus_valid(valid[0]), .ibus_addr(addr),
		.ibus_write(write), .ibus_pid(process_identifier), .ibus_rsp_valid(), .ibus_hit(), .ibus_grant,
		.ibus_phys_addr, .dbus_valid(valid[1]), .dbus_addr(addr), .dbus_write(write),
		.dbus_pid(process_identifier), .dbus_rsp_valid(), .dbus_hit(), .dbus_grant, .dbus_phys_addr,
		.dma_valid(valid[2]), .dma_addr(addr), .dma_write(write), .dma_rsp_valid_q(),
		.dma_hit_q(), .dma_grant_q, .dma_mem_en_q, .dma_mem_write_q(), .dma_mem_addr_q());
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [2:0] p);
		@(negedge mclk);
		reg_we = 1'b1;
		reg_idx = i;
		reg_wdata = d;
		reg_pid = p;
		@(negedge mclk);
		reg_we = 1'b0;
		chk({31'h0, reg_refused_q}, {31'h0, p > 3'h1});
	endtask
	task automatic rd(input logic [5:0] i, input logic [31:0] e);
		@(negedge mclk);
		reg_re = 1'b1;
		reg_idx = i;
		@(negedge mclk);
		reg_re = 1'b0;
		chk(reg_rdata_q, e);
	endtask
	task automatic acc(input logic [1:0] b, input logic [31:0] a, input logic w,
		input logic [2:0] p, input logic g, input logic [31:0] pa);
		ismmu_requester_i.go(b, a, w, p);
		chk({30'h0, grant[b], dma_mem_en_q}, {30'h0, g, g & (b == 2'h2)});
		if (g && b != 2'h2)
			chk(b[0] ? dbus_phys_addr : ibus_phys_addr, pa);
	endtask
	task automatic results;
		$display("Checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge mclk);
		n_errors++;
		results();
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		rd(6'h22, 32'h0);
		rd(6'h20, 32'h0);
		wr(6'h20, 32'h1, 3'h5);
		rd(6'h20, 32'h0);
		wr(6'h22, 32'hffffffff, 3'h3);
		rd(6'h22, 32'h0);
		wr(6'h22, 32'h02000001, 3'h1);
		wr(6'h23, 32'h00000100, 3'h0);
		rd(6'h23, 32'h100);
		$display("register test done");
		for (int k = 0; k < 41; k++)
			acc(2'h2, 32'h3ffae010 + k * 32'h2000, k[0], 3'h5, k == 0 || k == 25 || k == 40,
				32'h0);
		acc(2'h2, 32'h3ffa0000, 1'b1, 3'h7, 1'b1, 32'h0);
		$display("dma test done");
		wr(6'h12, 32'h31, 3'h0);
		acc(2'h1, 32'h3ffc2345, 1'b1, 3'h3, 1'b1, 32'h3ffc4345);
		acc(2'h1, 32'h3ffc2345, 1'b0, 3'h4, 1'b0, 32'h0);
		acc(2'h1, 32'h3ffc4345, 1'b0, 3'h3, 1'b0, 32'h0);
		acc(2'h1, 32'h3ffc2345, 1'b1, 3'h0, 1'b1, 32'h3ffc2345);
		acc(2'h1, 32'h40082004, 1'b0, 3'h0, 1'b0, 32'h0);
		wr(6'h13, 32'h15, 3'h0);
		acc(2'h1, 32'h3ffca010, 1'b0, 3'h7, 1'b1, 32'h3ffc6010);
		wr(6'h13, 32'h75, 3'h6);
		rd(6'h13, 32'h15);
		$display("data unit test done");
		wr(6'h0f, 32'h21, 3'h1);
		acc(2'h0, 32'h40082004, 1'b0, 3'h2, 1'b1, 32'h4009e004);
		acc(2'h0, 32'h40082004, 1'b1, 3'h2, 1'b0, 32'h0);
		$display("code unit test done");
		wr(6'h21, 32'h1, 3'h0);
		wr(6'h21, 32'h2, 3'h4);
		rd(6'h21, 32'h1);
		acc(2'h1, 32'h3ffc1008, 1'b0, 3'h3, 1'b1, 32'h3ffc2008);
		acc(2'h1, 32'h3ffd0000, 1'b0, 3'h3, 1'b0, 32'h0);
		acc(2'h1, 32'h3ffd0000, 1'b1, 3'h1, 1'b1, 32'h3ffd0000);
		wr(6'h21, 32'h2, 3'h0);
		acc(2'h1, 32'h3ffc0810, 1'b0, 3'h3, 1'b1, 32'h3ffc1010);
		wr(6'h21, 32'h3, 3'h0);
		rd(6'h21, 32'h3);
		acc(2'h1, 32'h3ffc2345, 1'b1, 3'h3, 1'b1, 32'h3ffc4345);
		$display("page size test done");
		results();
	end
endmodule
`default_nettype wire
